// *** adc_port_defines.vh ***
`ifndef ADC_PORT_DEFINES_VH
`define ADC_PORT_DEFINES_VH

// serial word and buffer geometry
`define WORD_BITS        24
`define BIT_CNT_W        5
`define WORD_BITS_CNT    5'h18
`define FIFO_DEPTH       8
`define FIFO_ADDR_W      3

// control word fields, msb first on the wire
`define CTL_MODE_HI      23
`define CTL_MODE_LO      21
`define CTL_POLARITY_BIT 12
`define CTL_RESET_VALUE  24'h00_0000
`define CAL_RESET_VALUE  24'h00_0000

// operating modes held in the control word
`define MODE_NORMAL      3'h0
`define MODE_SELF_CAL    3'h1
`define MODE_SYS_ZERO    3'h2
`define MODE_SYS_FULL    3'h3
`define MODE_SYS_OFFSET  3'h4
`define MODE_BACKGROUND  3'h5
`define MODE_ZERO_COEF   3'h6
`define MODE_FULL_COEF   3'h7

// link timing
`define REF_PERIOD_NS    100
`define SCLK_PERIOD_NS   800
`define SCLK_HALF_CYC    (`SCLK_PERIOD_NS / (2 * `REF_PERIOD_NS))
`define HALF_CNT_W       3

`endif

// *** pin_sync.v ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter WIDTH = 1
) (
	input  wire             ref_clk,
	input  wire             rstn,
	input  wire             clkEn,
	input  wire [WIDTH-1:0] pinIn,
	output reg  [WIDTH-1:0] pinSync
);

	// first stage is read by the second stage only
	reg [WIDTH-1:0] stage1_r;

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stage1_r <= {WIDTH{1'b0}};
			pinSync  <= {WIDTH{1'b0}};
		end
		else if (clkEn)
		begin
			stage1_r <= pinIn;
			pinSync  <= stage1_r;
		end
	end

endmodule
`default_nettype wire

// *** word_fifo.v ***
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
	parameter WIDTH  = 24,
	parameter DEPTH  = 8,
	parameter ADDR_W = 3
) (
	input  wire             ref_clk,
	input  wire             rstn,
	input  wire             clkEn,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);

	reg [WIDTH-1:0]  mem_r [0:DEPTH-1];
	reg [ADDR_W-1:0] wrPtr_r;
	reg [ADDR_W-1:0] rdPtr_r;
	reg [ADDR_W:0]   count_r;

	wire doPush;
	wire doPop;

	assign inReady  = (count_r != DEPTH[ADDR_W:0]);
	assign outValid = (count_r != {(ADDR_W+1){1'b0}});
	assign outData  = mem_r[rdPtr_r];
	assign doPush   = inValid & inReady;
	assign doPop    = outValid & outReady;

	always @(posedge ref_clk)
	begin
		if (clkEn && doPush)
			mem_r[wrPtr_r] <= inData;
	end

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wrPtr_r <= {ADDR_W{1'b0}};
			rdPtr_r <= {ADDR_W{1'b0}};
			count_r <= {(ADDR_W+1){1'b0}};
		end
		else if (clkEn)
		begin
			if (doPush)
				wrPtr_r <= (wrPtr_r == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : wrPtr_r + 1'b1;
			if (doPop)
				rdPtr_r <= (rdPtr_r == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : rdPtr_r + 1'b1;
			if (doPush && !doPop)
				count_r <= count_r + 1'b1;
			else if (doPop && !doPush)
				count_r <= count_r - 1'b1;
		end
	end

endmodule
`default_nettype wire

// *** adc_serial_host_port.v ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_defines.vh"

module adc_serial_host_port (
	input  wire                    ref_clk,
	input  wire                    rstn,
	input  wire                    clkEn,
	input  wire                    selfClockMode,
	input  wire                    sclkIn,
	output reg                     sclkOut,
	output wire                    sclkOe,
	input  wire                    readFrameSyncN,
	input  wire                    writeFrameSyncN,
	input  wire                    registerSelect,
	input  wire                    serialDataIn,
	output reg                     serialDataOut,
	output wire                    serialDataOe,
	output reg                     resultReadyN,
	input  wire [`WORD_BITS-1:0]   sampleData,
	input  wire                    sampleValid,
	output wire                    sampleReady,
	input  wire                    calDone,
	output reg                     calStart,
	output reg  [`WORD_BITS-1:0]   controlWord,
	output reg  [`WORD_BITS-1:0]   zeroCoef,
	output reg  [`WORD_BITS-1:0]   fullCoef
);

	localparam [2:0] RD_IDLE = 3'b001;
	localparam [2:0] RD_SHIFT = 3'b010;
	localparam [2:0] RD_WAIT = 3'b100;

	localparam [1:0] SRC_RESULT = 2'h0;
	localparam [1:0] SRC_CONTROL = 2'h1;
	localparam [1:0] SRC_ZERO = 2'h2;
	localparam [1:0] SRC_FULL = 2'h3;

	wire [5:0] pinSync;
	wire       sclkS;
	wire       rfsS;
	wire       tfsS;
	wire       dataS;
	wire       selS;
	wire       selfS;

	wire [`WORD_BITS-1:0] fifoData;
	wire                  fifoValid;
	wire                  fifoReady;

	reg                   rfsPrev_r;
	reg                   tfsPrev_r;
	reg                   sclkPrev_r;
	reg                   selfMode_r;
	reg  [`HALF_CNT_W-1:0] halfCnt_r;
	reg                   genRise;
	reg                   genFall;

	reg  [2:0]            rdState_r;
	reg  [2:0]            rdState_nxt;
	reg  [1:0]            rdSrc_r;
	reg  [`WORD_BITS-1:0] shiftOut_r;
	reg  [`BIT_CNT_W-1:0] rdCnt_r;
	reg  [`WORD_BITS-1:0] resultHold_r;

	reg                   wrActive_r;
	reg                   wrSel_r;
	reg  [`WORD_BITS-1:0] shiftIn_r;
	reg  [`BIT_CNT_W-1:0] wrCnt_r;

	wire [2:0]            mode;
	wire                  rfsFall;
	wire                  tfsFall;
	wire                  tfsRise;
	wire                  sclkRise;
	wire                  sclkFall;
	wire                  rdRun;
	wire                  wrRun;
	wire                  rdLast;
	wire                  resultLoad;
	wire [`WORD_BITS-1:0] codedSample;

	pin_sync #(
		.WIDTH(6)
	) u_pin_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.clkEn   (clkEn),
		// syncs enter inverted so the all-zero reset value reads as idle
		.pinIn   ({selfClockMode, registerSelect, serialDataIn, ~writeFrameSyncN, ~readFrameSyncN, sclkIn}),
		.pinSync (pinSync)
	);

	assign sclkS = pinSync[0];
	assign rfsS  = ~pinSync[1];
	assign tfsS  = ~pinSync[2];
	assign dataS = pinSync[3];
	assign selS  = pinSync[4];
	assign selfS = pinSync[5];

	// converter may stall on a full buffer rather than drop words
	word_fifo #(
		.WIDTH  (`WORD_BITS),
		.DEPTH  (`FIFO_DEPTH),
		.ADDR_W (`FIFO_ADDR_W)
	) u_word_fifo (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.clkEn    (clkEn),
		.inData   (sampleData),
		.inValid  (sampleValid),
		.inReady  (sampleReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (fifoReady)
	);

	assign mode = controlWord[`CTL_MODE_HI:`CTL_MODE_LO];

	assign codedSample = controlWord[`CTL_POLARITY_BIT] ? fifoData :
		{~fifoData[`WORD_BITS-1], fifoData[`WORD_BITS-2:0]};

	// frame syncs are active low; an edge is seen on the synchronised copy
	assign rfsFall = rfsPrev_r & ~rfsS;
	assign tfsFall = tfsPrev_r & ~tfsS;
	assign tfsRise = ~tfsPrev_r & tfsS;

	assign rdRun = (rdState_r == RD_SHIFT) & ~rfsS;
	assign wrRun = wrActive_r & ~tfsS & (wrCnt_r != `WORD_BITS_CNT);

	assign sclkRise = selfMode_r ? genRise : (sclkS & ~sclkPrev_r);
	assign sclkFall = selfMode_r ? genFall : (~sclkS & sclkPrev_r);

	assign rdLast = sclkRise & rdRun & (rdCnt_r == `WORD_BITS_CNT - 1'b1);

	// holding word reloads only once the previous one has gone out
	assign resultLoad = resultReadyN & fifoValid & (rdState_r == RD_IDLE);
	assign fifoReady  = resultLoad;

	// clock pin driven in self mode only
	// external mode leaves clock to host
	assign sclkOe = selfMode_r & (rdRun | wrRun);

	// data only while read frame low
	assign serialDataOe = rdRun;

	always @*
	begin
		genRise = 1'b0;
		genFall = 1'b0;
		if ((rdRun | wrRun) && halfCnt_r == `SCLK_HALF_CYC - 1)
		begin
			genRise = ~sclkOut;
			genFall = sclkOut;
		end
	end

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rfsPrev_r  <= 1'b1;
			tfsPrev_r  <= 1'b1;
			sclkPrev_r <= 1'b0;
			selfMode_r <= 1'b0;
		end
		else if (clkEn)
		begin
			rfsPrev_r  <= rfsS;
			tfsPrev_r  <= tfsS;
			sclkPrev_r <= sclkS;
			// mode is only changed between frames to avoid a glitching clock
			if (rfsS && tfsS)
				selfMode_r <= selfS;
		end
	end

	// self clock begins after sync falls
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			halfCnt_r <= {`HALF_CNT_W{1'b0}};
			sclkOut   <= 1'b0;
		end
		else if (clkEn)
		begin
			if (!(rdRun | wrRun))
			begin
				halfCnt_r <= {`HALF_CNT_W{1'b0}};
				sclkOut   <= 1'b0;
			end
			else if (halfCnt_r == `SCLK_HALF_CYC - 1)
			begin
				halfCnt_r <= {`HALF_CNT_W{1'b0}};
				sclkOut   <= ~sclkOut;
			end
			else
				halfCnt_r <= halfCnt_r + 1'b1;
		end
	end

	always @*
	begin
		rdState_nxt = rdState_r;
		case (rdState_r)
			RD_IDLE:
			begin
				// result only when ready is low
				if (rfsFall && (!selS || (mode == `MODE_ZERO_COEF) || (mode == `MODE_FULL_COEF) || !resultReadyN))
					rdState_nxt = RD_SHIFT;
			end
			RD_SHIFT:
			begin
				if (rfsS)
					rdState_nxt = RD_IDLE;
				else if (rdLast)
					rdState_nxt = RD_WAIT;
			end
			RD_WAIT:
			begin
				if (rfsS)
					rdState_nxt = RD_IDLE;
			end
			default:
				rdState_nxt = RD_IDLE;
		endcase
	end

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdState_r     <= RD_IDLE;
			rdSrc_r       <= SRC_RESULT;
			shiftOut_r    <= {`WORD_BITS{1'b0}};
			rdCnt_r       <= {`BIT_CNT_W{1'b0}};
			serialDataOut <= 1'b0;
		end
		else if (clkEn)
		begin
			rdState_r <= rdState_nxt;
			if (rdState_r == RD_IDLE && rdState_nxt == RD_SHIFT)
			begin
				rdCnt_r <= {`BIT_CNT_W{1'b0}};
				if (!selS)
				begin
					rdSrc_r       <= SRC_CONTROL;
					shiftOut_r    <= {controlWord[`WORD_BITS-2:0], 1'b0};
					serialDataOut <= controlWord[`WORD_BITS-1];
				end
				else if (mode == `MODE_ZERO_COEF)
				begin
					rdSrc_r       <= SRC_ZERO;
					shiftOut_r    <= {zeroCoef[`WORD_BITS-2:0], 1'b0};
					serialDataOut <= zeroCoef[`WORD_BITS-1];
				end
				else if (mode == `MODE_FULL_COEF)
				begin
					rdSrc_r       <= SRC_FULL;
					shiftOut_r    <= {fullCoef[`WORD_BITS-2:0], 1'b0};
					serialDataOut <= fullCoef[`WORD_BITS-1];
				end
				else
				begin
					rdSrc_r       <= SRC_RESULT;
					shiftOut_r    <= {resultHold_r[`WORD_BITS-2:0], 1'b0};
					serialDataOut <= resultHold_r[`WORD_BITS-1];
				end
			end
			else if (rdRun)
			begin
				if (sclkRise)
					rdCnt_r <= rdCnt_r + 1'b1;
				// next bit after each falling edge, msb first
				if (sclkFall && rdCnt_r != {`BIT_CNT_W{1'b0}})
				begin
					serialDataOut <= shiftOut_r[`WORD_BITS-1];
					shiftOut_r    <= {shiftOut_r[`WORD_BITS-2:0], 1'b0};
				end
			end
		end
	end

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			resultHold_r <= {`WORD_BITS{1'b0}};
			resultReadyN <= 1'b1;
		end
		else if (clkEn)
		begin
			if (resultLoad)
				resultHold_r <= codedSample;
			if (resultLoad || calDone)
				resultReadyN <= 1'b0;
			else if (rdLast && rdSrc_r == SRC_RESULT)
				resultReadyN <= 1'b1;
		end
	end

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wrActive_r  <= 1'b0;
			wrSel_r     <= 1'b0;
			shiftIn_r   <= {`WORD_BITS{1'b0}};
			wrCnt_r     <= {`BIT_CNT_W{1'b0}};
			controlWord <= `CTL_RESET_VALUE;
			zeroCoef    <= `CAL_RESET_VALUE;
			fullCoef    <= `CAL_RESET_VALUE;
			calStart    <= 1'b0;
		end
		else if (clkEn)
		begin
			calStart <= 1'b0;
			if (tfsFall)
			begin
				wrActive_r <= 1'b1;
				wrSel_r    <= selS;
				wrCnt_r    <= {`BIT_CNT_W{1'b0}};
			end
			else if (wrRun && sclkRise)
			begin
				shiftIn_r <= {shiftIn_r[`WORD_BITS-2:0], dataS};
				wrCnt_r   <= wrCnt_r + 1'b1;
			end
			else if (tfsRise && wrActive_r)
			begin
				wrActive_r <= 1'b0;
				if (wrCnt_r == `WORD_BITS_CNT)
				begin
					if (!wrSel_r)
					begin
						controlWord <= shiftIn_r;
						calStart    <= (shiftIn_r[`CTL_MODE_HI:`CTL_MODE_LO] != `MODE_NORMAL) &&
							(shiftIn_r[`CTL_MODE_HI:`CTL_MODE_LO] != `MODE_ZERO_COEF) &&
							(shiftIn_r[`CTL_MODE_HI:`CTL_MODE_LO] != `MODE_FULL_COEF);
					end
					else if (mode == `MODE_ZERO_COEF)
						zeroCoef <= shiftIn_r;
					else if (mode == `MODE_FULL_COEF)
						fullCoef <= shiftIn_r;
				end
			end
			// one-shot calibrations fall back to normal mode when done
			if (calDone && !(tfsRise && wrActive_r && !wrSel_r && wrCnt_r == `WORD_BITS_CNT) &&
				mode != `MODE_BACKGROUND && mode != `MODE_ZERO_COEF && mode != `MODE_FULL_COEF)
				controlWord[`CTL_MODE_HI:`CTL_MODE_LO] <= `MODE_NORMAL;
		end
	end

endmodule
`default_nettype wire

// *** adc_host_port_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_defines.vh"

module adc_host_port_props (
	input wire logic                  ref_clk,
	input wire logic                  rstn,
	input wire logic                  selfClockMode,
	input wire logic                  readFrameSyncN,
	input wire logic                  writeFrameSyncN,
	input wire logic                  registerSelect,
	input wire logic                  sampleValid,
	input wire logic                  sampleReady,
	input wire logic                  calDone,
	input wire logic                  calStart,
	input wire logic                  sclkOe,
	input wire logic                  serialDataOe,
	input wire logic                  resultReadyN,
	input wire logic [`WORD_BITS-1:0] controlWord
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	// coefficient modes 6 and 7 reroute select-high reads
	wire normalSel = registerSelect && (controlWord[23:22] != 2'b11);

	a_data_in_frame: assert property (readFrameSyncN [*6] |-> !serialDataOe)
		else $error("data line driven outside a read frame");
	a_self_clock_on: assert property ($fell(readFrameSyncN) && selfClockMode && !registerSelect |-> ##[2:6] sclkOe)
		else $error("self clock not started by read frame");
	a_ext_clock_off: assert property (!selfClockMode [*6] |-> !sclkOe)
		else $error("clock driven in external clock mode");
	a_ready_falls: assert property (sampleValid && sampleReady && resultReadyN && readFrameSyncN && writeFrameSyncN
		|-> ##[1:4] !resultReadyN)
		else $error("ready did not fall for new result");
	a_ready_release: assert property ($fell(serialDataOe) && normalSel |-> ##[0:2] resultReadyN)
		else $error("ready not released after result word");
	a_cal_ready: assert property (calDone && resultReadyN |-> ##[1:2] !resultReadyN)
		else $error("ready did not mark calibration end");
	a_cal_mode_clear: assert property (calDone && controlWord[23:21] inside {3'h1, 3'h2, 3'h3, 3'h4}
		|-> ##[1:2] controlWord[23:21] == 3'h0)
		else $error("mode not cleared after calibration");
	a_no_result_drive: assert property ($fell(readFrameSyncN) && normalSel && resultReadyN
		|-> ##1 !serialDataOe [*6])
		else $error("result driven while ready high");
	a_no_mid_write: assert property (!writeFrameSyncN [*8] |-> $stable(controlWord))
		else $error("control changed inside a write frame");
	a_cal_start_mode: assert property (calStart |-> ##[0:1] controlWord[23:21] inside {[3'h1:3'h5]})
		else $error("calibration start without calibration mode");

	cover property ($fell(resultReadyN));
	cover property (calStart);
	cover property ($rose(sclkOe));
endmodule

bind adc_serial_host_port adc_host_port_props adc_host_port_props_i (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.selfClockMode(selfClockMode),
	.readFrameSyncN(readFrameSyncN),
	.writeFrameSyncN(writeFrameSyncN),
	.registerSelect(registerSelect),
	.sampleValid(sampleValid),
	.sampleReady(sampleReady),
	.calDone(calDone),
	.calStart(calStart),
	.sclkOe(sclkOe),
	.serialDataOe(serialDataOe),
	.resultReadyN(resultReadyN),
	.controlWord(controlWord)
);
`default_nettype wire

// *** host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module host_model (
	input  wire logic ref_clk,
	input  wire logic devOut,
	input  wire logic devOe,
	output var logic  sclk,
	output var logic  readSyncN,
	output var logic  writeSyncN,
	output var logic  sel,
	output wire logic line
);
	logic hOe    = 1'h0;
	logic hBit   = 1'h0;
	logic idle   = 1'h0;
	logic oeSeen = 1'h0;

	initial
	begin
		sclk = 1'h0;
		readSyncN = 1'h1;
		writeSyncN = 1'h1;
		sel = 1'h0;
	end
	// released line toggles so a stale bit never reads as valid
	always @(posedge ref_clk)
		idle <= ~idle;
	always @(posedge ref_clk)
		if (devOe)
			oeSeen <= 1'h1;
	assign line = devOe ? devOut : (hOe ? hBit : idle);

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic xfer(input logic rd, input logic s, input logic [23:0] wv, input int n, output logic [23:0] rv);
		int i;
		rv = 24'h00_0000;
		@(posedge ref_clk);
		sel <= s;
		oeSeen <= 1'h0;
		readSyncN <= !rd;
		writeSyncN <= rd;
		hOe <= !rd;
		tick(4);
		for (i = 0; i < n; i++)
		begin
			hBit <= (i < 24) ? wv[23 - i] : 1'h1;
			tick(4);
			rv = {rv[22:0], line};
			sclk <= 1'h1;
			tick(4);
			sclk <= 1'h0;
		end
		tick(4);
		readSyncN <= 1'h1;
		writeSyncN <= 1'h1;
		tick(4);
		hOe <= 1'h0;
		tick(6);
	endtask

	// read frame left to the device clock
	task automatic hold(input int n);
		@(posedge ref_clk);
		sel <= 1'h0;
		readSyncN <= 1'h0;
		tick(n);
		readSyncN <= 1'h1;
		tick(8);
	endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_defines.vh"

module testbench;
	logic        ref_clk       = 1'h0;
	logic        rstn          = 1'h0;
	logic        clkEn         = 1'h1;
	logic        selfClockMode = 1'h0;
	logic        calDone       = 1'h0;
	logic        sampleValid   = 1'h0;
	logic [23:0] sampleData    = 24'h00_0000;
	logic [23:0] rv;
	wire         sclkOut, sclkOe, hSclk, rsN, wsN, sel, line, dOut, dOe, rdyN, sReady, calStart;
	wire  [23:0] ctl, zc, fc;
	int          num_errors = 0;
	int          n_tests    = 0;
	int          cyc        = 0;
	int          calSeen    = 0;
	int          acc, i;
	wire         sclkLine   = sclkOe ? sclkOut : hSclk;

	always #50 ref_clk = ~ref_clk;

	adc_serial_host_port adc_serial_host_port_i (
		.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .selfClockMode(selfClockMode),
		.sclkIn(sclkLine), .sclkOut(sclkOut), .sclkOe(sclkOe), .readFrameSyncN(rsN),
		.writeFrameSyncN(wsN), .registerSelect(sel), .serialDataIn(line), .serialDataOut(dOut),
		.serialDataOe(dOe), .resultReadyN(rdyN), .sampleData(sampleData), .sampleValid(sampleValid),
		.sampleReady(sReady), .calDone(calDone), .calStart(calStart), .controlWord(ctl),
		.zeroCoef(zc), .fullCoef(fc)
	);
	host_model host_model_i (
		.ref_clk(ref_clk), .devOut(dOut), .devOe(dOe), .sclk(hSclk), .readSyncN(rsN),
		.writeSyncN(wsN), .sel(sel), .line(line)
	);

	task automatic report_and_stop;
		$display("errors=%0d tests=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic s, input logic [23:0] v, input int n);
		host_model_i.xfer(1'h0, s, v, n, rv);
	endtask

	task automatic rd(input logic s);
		host_model_i.xfer(1'h1, s, 24'h00_0000, 24, rv);
	endtask

	// ready read at the falling edge, so valid only meets a settled ready
	task automatic push(input logic [23:0] v);
		logic ok;
		@(negedge ref_clk);
		ok = sReady;
		@(posedge ref_clk);
		sampleData <= v;
		sampleValid <= ok;
		acc += ok;
		@(posedge ref_clk);
		sampleValid <= 1'h0;
	endtask

	always @(posedge ref_clk)
	begin
		if (calStart)
			calSeen <= calSeen + 1;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			report_and_stop;
		end
	end

	initial
	begin
		repeat (20) @(posedge ref_clk);
		rstn <= 1'h1;
		host_model_i.tick(6);
		cmp(ctl, `CTL_RESET_VALUE);
		cmp(zc, `CAL_RESET_VALUE);
		cmp(24'(rdyN), 24'h00_0001);
		wr(1'h0, 24'h03_5A5C, 24);
		cmp(ctl, 24'h03_5A5C);
		wr(1'h0, 24'h00_0F0F, 12);
		cmp(ctl, 24'h03_5A5C);
		wr(1'h0, 24'h01_3C3C, 30);
		cmp(ctl, 24'h01_3C3C);
		// a frame sent while frozen must leave control alone
		@(posedge ref_clk);
		clkEn <= 1'h0;
		wr(1'h0, 24'h12_3456, 24);
		clkEn <= 1'h1;
		host_model_i.tick(4);
		cmp(ctl, 24'h01_3C3C);
		rd(1'h0);
		cmp(rv, 24'h01_3C3C);
		rd(1'h1);
		cmp(24'(host_model_i.oeSeen), 24'h00_0000);
		acc = 0;
		push(24'h80_1234);
		host_model_i.tick(4);
		cmp(24'(rdyN), 24'h00_0000);
		rd(1'h1);
		cmp(rv, 24'h80_1234);
		cmp(24'(rdyN), 24'h00_0001);
		wr(1'h0, 24'h00_0ABC, 24);
		acc = 0;
		for (i = 0; i < 10; i++)
			push(24'h10_0000 + 24'(i));
		cmp(24'(acc), 24'h00_0009);
		cmp(24'(sReady), 24'h00_0000);
		for (i = 0; i < 9; i++)
		begin
			rd(1'h1);
			cmp(rv, 24'h90_0000 + 24'(i));
		end
		cmp(24'(rdyN), 24'h00_0001);
		cmp(24'(sReady), 24'h00_0001);
		wr(1'h0, 24'hC0_0000, 24);
		wr(1'h1, 24'h5A_A5C3, 24);
		cmp(zc, 24'h5A_A5C3);
		rd(1'h1);
		cmp(rv, 24'h5A_A5C3);
		wr(1'h0, 24'hE0_0000, 24);
		wr(1'h1, 24'h3C_C3A5, 24);
		cmp(fc, 24'h3C_C3A5);
		wr(1'h0, 24'h00_0000, 24);
		@(posedge ref_clk);
		selfClockMode <= 1'h1;
		host_model_i.tick(8);
		fork
			host_model_i.hold(240);
			begin
				host_model_i.tick(10);
				cmp(24'({sclkOe, dOe}), 24'h00_0003);
			end
		join
		selfClockMode <= 1'h0;
		host_model_i.tick(8);
		wr(1'h0, 24'h20_0000, 24);
		cmp(24'(calSeen), 24'h00_0001);
		@(posedge ref_clk);
		calDone <= 1'h1;
		@(posedge ref_clk);
		calDone <= 1'h0;
		host_model_i.tick(3);
		cmp(24'(rdyN), 24'h00_0000);
		cmp(24'(ctl[23:21]), 24'h00_0000);
		report_and_stop;
	end
endmodule
`default_nettype wire
